// File: logic/gdp_cfg.svh
// Constants for the instrument command interpreter: offsets, codes, defaults
//
// Operation
// - Command letters are taken in upper or lower case with the same meaning.
// - The offset-on command captures the present reading as the offset of the function.
// - The offset-off command cancels the stored offset so readings come out uncorrected.
// - Only one offset is held; a new capture replaces the old one.
// - The status query reports offset on or off but never the offset value.
// - Power-up and device clear leave the offset disabled.
// - Display-normal runs the display normally and is the power-up and clear state.
// - Display-blank blanks the display while measuring and bus traffic go on.
// - Service mask code 00 disables requests and is the default; 01 asks on overrange.
// - Mask code 16 asks on data available, 32 on any error, and sums combine them.
// - The suffix commands turn the units suffix on readings off or on.
// - The terminator command picks one of six string endings, CR LF with EOI by default.
`ifndef GDP_CFG_SVH
`define GDP_CFG_SVH
// Register byte offsets
`define GDP_ADDR_STS 4'h0
`define GDP_ADDR_CLR 4'h4
`define GDP_ADDR_EN 4'h8
`define GDP_ADDR_CFG 4'hC
// Characters
`define GDP_CH_CR 8'h0D
`define GDP_CH_LF 8'h0A
`define GDP_CH_SP 8'h20
`define GDP_CH_STAR 8'h2A
`define GDP_CH_QM 8'h3F
`define GDP_CH_DIG0 8'h30
`define GDP_CH_DIG9 8'h39
`define GDP_CH_A 8'h41
`define GDP_CH_Z 8'h5A
`define GDP_CH_LA 8'h61
`define GDP_CH_LZ 8'h7A
`define GDP_CH_LB 8'h62
`define GDP_CASE 8'h20
`define GDP_TEN 8'h0A
// Command letters
`define GDP_CH_B 8'h42
`define GDP_CH_D 8'h44
`define GDP_CH_F 8'h46
`define GDP_CH_G 8'h47
`define GDP_CH_N 8'h4E
`define GDP_CH_P 8'h50
`define GDP_CH_R 8'h52
`define GDP_CH_S 8'h53
`define GDP_CH_T 8'h54
`define GDP_CH_W 8'h57
`define GDP_CH_X 8'h58
`define GDP_CH_Y 8'h59
`define GDP_CH_ZZ 8'h5A
// Arguments and defaults
`define GDP_ARG_ONE 8'h01
`define GDP_TERM_MAX 8'h05
`define GDP_TERM_DEF 3'h0
`define GDP_MASK_DEF 8'h00
`define GDP_MSK_OVR 0
`define GDP_MSK_DAV 4
`define GDP_MSK_ERR 5
// Interrupt status bits
`define GDP_IRQ_W 4
`define GDP_IRQ_ERR 0
`define GDP_IRQ_EXEC 1
`define GDP_IRQ_SRQ 2
`define GDP_IRQ_OFS 3
// Configuration readback fields
`define GDP_CFG_OFS 0
`define GDP_CFG_BLK 1
`define GDP_CFG_SFX 2
`define GDP_CFG_TRM 5:3
`define GDP_CFG_MSK 15:8
`define GDP_CFG_SRQ 16
`endif

// File: logic/gdp_pkg.sv
// Types shared by the command interpreter modules
package gdp_pkg;
    typedef enum logic [1:0] {
        LX_IDLE = 2'b00,
        LX_LETTER = 2'b01,
        LX_NUM = 2'b10
    } gdp_lex_st_t;
    typedef logic [7:0] gdp_byte_t;
    typedef struct packed {
        logic ofs_v;
        logic ofs;
        logic dsp_v;
        logic dsp;
        logic sfx_v;
        logic sfx;
        logic trm_v;
        logic [2:0] trm;
        logic msk_v;
        logic [7:0] msk;
        logic [7:0] num;
        logic qry_v;
        logic [3:0] qry;
    } gdp_pend_t;
endpackage : gdp_pkg

// File: logic/gdp_tok_if.sv
// Token carrier from the character scanner to the command core
`timescale 1ns/1ps
interface gdp_tok_if;
    logic tok_vld;
    logic [7:0] tok_cmd;
    logic [7:0] tok_arg;
    logic exec;
    logic trig;
    logic clr;
    logic err;
    modport lex (output tok_vld, tok_cmd, tok_arg, exec, trig, clr, err);
    modport core (input tok_vld, tok_cmd, tok_arg, exec, trig, clr, err);
endinterface : gdp_tok_if

// File: logic/gdp_lex.sv
// Character scanner: folds case and splits the byte stream into tokens
`timescale 1ns/1ps
`include "gdp_cfg.svh"
module gdp_lex (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Received bytes from the bus interface logic
    input wire logic rx_vld,
    input wire gdp_pkg::gdp_byte_t rx_byte,
    input wire logic rx_eoi,
    input wire logic rx_get,
    input wire logic rem_lsn,
    // Tokens out
    gdp_tok_if.lex tok
);
    import gdp_pkg::*;

    function automatic gdp_byte_t gdp_fold(input gdp_byte_t c);
        if (c >= `GDP_CH_LA && c <= `GDP_CH_LZ) begin
            return c - `GDP_CASE;
        end
        return c;
    endfunction : gdp_fold

    function automatic logic gdp_is_dig(input gdp_byte_t c);
        return (c >= `GDP_CH_DIG0) && (c <= `GDP_CH_DIG9);
    endfunction : gdp_is_dig

    gdp_lex_st_t st_ff, nxt_st;
    gdp_byte_t let_ff, nxt_let, acc_ff, nxt_acc, c;
    logic take, t_vld, t_exec, t_trig, t_clr, t_err;
    gdp_byte_t t_cmd, t_arg;

    assign take = rx_vld && rem_lsn;
    assign c = gdp_fold(rx_byte);

    // Next token; a half-typed letter at a terminator is a syntax error
    always_comb begin
        nxt_st = st_ff;
        nxt_let = let_ff;
        nxt_acc = acc_ff;
        t_vld = 1'b0;
        t_cmd = let_ff;
        t_arg = 8'h00;
        t_exec = 1'b0;
        t_trig = 1'b0;
        t_clr = 1'b0;
        t_err = 1'b0;
        if (take) begin
            if (st_ff == LX_LETTER && c != `GDP_CH_CR && c != `GDP_CH_LF) begin
                t_vld = gdp_is_dig(c);
                t_arg = c - `GDP_CH_DIG0;
                t_err = !gdp_is_dig(c);
                nxt_st = LX_IDLE;
            end else if (st_ff == LX_NUM && gdp_is_dig(c)) begin
                nxt_acc = 8'(acc_ff * `GDP_TEN + (c - `GDP_CH_DIG0));
            end else begin
                // A number ends at the first non-digit
                if (st_ff == LX_NUM) begin
                    t_vld = 1'b1;
                    t_cmd = `GDP_CH_N;
                    t_arg = acc_ff;
                end
                t_err = (st_ff == LX_LETTER);
                nxt_st = LX_IDLE;
                if (c == `GDP_CH_CR || c == `GDP_CH_LF) begin
                    t_exec = 1'b1;
                end else if (c == `GDP_CH_STAR) begin
                    t_clr = 1'b1;
                end else if (c == `GDP_CH_QM) begin
                    t_trig = 1'b1;
                end else if (c == `GDP_CH_N) begin
                    nxt_st = LX_NUM;
                    nxt_acc = 8'h00;
                end else if (c >= `GDP_CH_A && c <= `GDP_CH_Z) begin
                    nxt_st = LX_LETTER;
                    nxt_let = c;
                end else if (c != `GDP_CH_SP) begin
                    t_err = 1'b1;
                end
            end
            if (rx_eoi) begin
                t_exec = 1'b1;
                if (nxt_st == LX_LETTER) begin
                    t_err = 1'b1;
                end
                if (nxt_st == LX_NUM) begin
                    t_vld = 1'b1;
                    t_cmd = `GDP_CH_N;
                    t_arg = nxt_acc;
                end
                nxt_st = LX_IDLE;
            end
        end
        if (rx_get) begin
            t_exec = 1'b1;
            t_trig = 1'b1;
        end
    end

    // Scanner state
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= LX_IDLE;
            let_ff <= 8'h00;
            acc_ff <= 8'h00;
        end else begin
            st_ff <= nxt_st;
            let_ff <= nxt_let;
            acc_ff <= nxt_acc;
        end
    end

    // Registered token outputs
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tok.tok_vld <= 1'b0;
            tok.tok_cmd <= 8'h00;
            tok.tok_arg <= 8'h00;
            tok.exec <= 1'b0;
            tok.trig <= 1'b0;
            tok.clr <= 1'b0;
            tok.err <= 1'b0;
        end else begin
            tok.tok_vld <= t_vld;
            tok.tok_cmd <= t_cmd;
            tok.tok_arg <= t_arg;
            tok.exec <= t_exec;
            tok.trig <= t_trig;
            tok.clr <= t_clr;
            tok.err <= t_err;
        end
    end

    default clocking lx_cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    lower_case_fold_a: assert property (
        (take && st_ff == LX_IDLE && rx_byte == `GDP_CH_LB && !rx_eoi)
        |=> (st_ff == LX_LETTER && let_ff == `GDP_CH_B))
        else $error("lower case letter not folded");
endmodule : gdp_lex

// File: logic/gdp_top.sv
// Command interpreter core: settings, offset, service request and registers
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "gdp_cfg.svh"
module gdp_top #(
    parameter int RW = 24
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Bus interface logic
    input wire logic rx_vld,
    input wire gdp_pkg::gdp_byte_t rx_byte,
    input wire logic rx_eoi,
    input wire logic rx_get,
    input wire logic rx_dev_clr,
    input wire logic rem_lsn,
    input wire logic srq_ack,
    // Measurement core
    input wire logic rdg_vld,
    input wire logic signed [RW-1:0] rdg_val,
    input wire logic rdg_ovr,
    input wire logic meas_err,
    // Settings and results
    output logic signed [RW-1:0] rdg_out_ff,
    output logic rdg_out_vld_ff,
    output logic offset_en_ff,
    output logic disp_blank_ff,
    output logic suffix_en_ff,
    output logic [2:0] term_sel_ff,
    output gdp_pkg::gdp_byte_t srq_mask_ff,
    output logic srq_ff,
    output logic meas_trig_ff,
    output logic qry_vld_ff,
    output logic [3:0] qry_code_ff,
    output logic qry_ofs_ff,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata_ff,
    output logic irq_ff
);
    import gdp_pkg::*;
    gdp_tok_if tok ();

    gdp_lex u_lex (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .rx_vld(rx_vld),
        .rx_byte(rx_byte),
        .rx_eoi(rx_eoi),
        .rx_get(rx_get),
        .rem_lsn(rem_lsn),
        .tok(tok.lex)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Pending commands
    gdp_pend_t pend_ff, pm;
    logic cmd_err, commit, dclr, err_evt;
    logic signed [RW-1:0] rdg_last_ff, offset_val_ff;
    // Binary switch commands accept only 0 or 1
    function automatic logic gdp_bin_ok(input gdp_byte_t a);
        return a <= `GDP_ARG_ONE;
    endfunction : gdp_bin_ok

    assign commit = tok.exec;
    assign dclr = rx_dev_clr || tok.clr;

    // Merge the token of this cycle so a terminator in the same cycle sees it
    always_comb begin
        pm = pend_ff;
        cmd_err = 1'b0;
        if (tok.tok_vld) begin
            case (tok.tok_cmd)
                `GDP_CH_B: begin
                    pm.ofs_v = gdp_bin_ok(tok.tok_arg);
                    pm.ofs = tok.tok_arg[0];
                    cmd_err = !gdp_bin_ok(tok.tok_arg);
                end
                `GDP_CH_D: begin
                    pm.dsp_v = gdp_bin_ok(tok.tok_arg);
                    pm.dsp = tok.tok_arg[0];
                    cmd_err = !gdp_bin_ok(tok.tok_arg);
                end
                `GDP_CH_Y: begin
                    pm.sfx_v = gdp_bin_ok(tok.tok_arg);
                    pm.sfx = tok.tok_arg[0];
                    cmd_err = !gdp_bin_ok(tok.tok_arg);
                end
                `GDP_CH_W: begin
                    pm.trm_v = tok.tok_arg <= `GDP_TERM_MAX;
                    pm.trm = tok.tok_arg[2:0];
                    cmd_err = tok.tok_arg > `GDP_TERM_MAX;
                end
                `GDP_CH_P: begin
                    // Only the mask put is handled here; any other P argument is ignored without error
                    pm.msk_v = (tok.tok_arg == `GDP_ARG_ONE) || pend_ff.msk_v;
                    pm.msk = (tok.tok_arg == `GDP_ARG_ONE) ? pend_ff.num : pend_ff.msk;
                end
                `GDP_CH_N: begin
                    pm.num = tok.tok_arg;
                end
                `GDP_CH_G: begin
                    pm.qry_v = 1'b1;
                    pm.qry = tok.tok_arg[3:0];
                end
                `GDP_CH_F, `GDP_CH_R, `GDP_CH_S, `GDP_CH_T, `GDP_CH_X, `GDP_CH_ZZ: begin
                    pm = pend_ff;
                end
                default: begin
                    cmd_err = 1'b1;
                end
            endcase
        end
    end
    assign err_evt = cmd_err || tok.err || meas_err;
    // Pending set is dropped on clear and after each execute
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_ff <= '0;
        end else if (dclr || commit) begin
            pend_ff <= '0;
        end else begin
            pend_ff <= pm;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Settings
    // clear defaults win over a commit
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            disp_blank_ff <= 1'b0;
            suffix_en_ff <= 1'b0;
            term_sel_ff <= `GDP_TERM_DEF;
            srq_mask_ff <= `GDP_MASK_DEF;
        end else if (dclr) begin
            disp_blank_ff <= 1'b0;
            suffix_en_ff <= 1'b0;
            term_sel_ff <= `GDP_TERM_DEF;
            srq_mask_ff <= `GDP_MASK_DEF;
        end else if (commit) begin
            if (pm.dsp_v) begin
                disp_blank_ff <= pm.dsp;
            end
            if (pm.sfx_v) begin
                suffix_en_ff <= pm.sfx;
            end
            if (pm.trm_v) begin
                term_sel_ff <= pm.trm;
            end
            if (pm.msk_v) begin
                srq_mask_ff <= pm.msk;
            end
        end
    end

    // Last raw reading, the source of an offset capture
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdg_last_ff <= '0;
        end else if (rdg_vld) begin
            rdg_last_ff <= rdg_val;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            offset_en_ff <= 1'b0;
            offset_val_ff <= '0;
        end else if (dclr) begin
            offset_en_ff <= 1'b0;
        end else if (commit && pm.ofs_v) begin
            offset_en_ff <= pm.ofs;
            if (pm.ofs) begin
                offset_val_ff <= rdg_last_ff;
            end
        end
    end

    // corrected reading; wraps at the reading width
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdg_out_ff <= '0;
            rdg_out_vld_ff <= 1'b0;
        end else begin
            rdg_out_vld_ff <= rdg_vld;
            if (rdg_vld) begin
                rdg_out_ff <= offset_en_ff ? RW'(rdg_val - offset_val_ff) : rdg_val;
            end
        end
    end

    // query carries only the offset state bit
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            qry_vld_ff <= 1'b0;
            qry_code_ff <= 4'h0;
            qry_ofs_ff <= 1'b0;
            meas_trig_ff <= 1'b0;
        end else begin
            qry_vld_ff <= commit && pm.qry_v && !dclr;
            meas_trig_ff <= tok.trig;
            if (commit && pm.qry_v) begin
                qry_code_ff <= pm.qry;
                qry_ofs_ff <= offset_en_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Service request
    logic srq_cond;
    assign srq_cond = (srq_mask_ff[`GDP_MSK_OVR] && rdg_vld && rdg_ovr)
        || (srq_mask_ff[`GDP_MSK_DAV] && rdg_vld)
        || (srq_mask_ff[`GDP_MSK_ERR] && err_evt);

    // A new condition beats a poll acknowledge in the same cycle
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            srq_ff <= 1'b0;
        end else if (srq_cond) begin
            srq_ff <= 1'b1;
        end else if (srq_ack || dclr) begin
            srq_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers and interrupt
    logic [`GDP_IRQ_W-1:0] sts_ff, en_ff, ev, clr_bits;
    logic wr_clr, wr_en;

    assign wr_clr = reg_wr && (reg_addr == `GDP_ADDR_CLR);
    assign wr_en = reg_wr && (reg_addr == `GDP_ADDR_EN);
    assign clr_bits = wr_clr ? reg_wdata[`GDP_IRQ_W-1:0] : '0;

    always_comb begin
        ev = '0;
        ev[`GDP_IRQ_ERR] = err_evt;
        ev[`GDP_IRQ_EXEC] = commit;
        ev[`GDP_IRQ_SRQ] = srq_cond && !srq_ff;
        ev[`GDP_IRQ_OFS] = commit && pm.ofs_v && pm.ofs && !dclr;
    end

    // Sticky status; an event in the clear cycle survives
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sts_ff <= '0;
        end else begin
            sts_ff <= (sts_ff & ~clr_bits) | ev;
        end
    end

    // Enable register and level interrupt
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            en_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            if (wr_en) begin
                en_ff <= reg_wdata[`GDP_IRQ_W-1:0];
            end
            irq_ff <= |(sts_ff & en_ff);
        end
    end

    // Read data in the cycle after the strobe only; unmapped reads zero
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_ff <= '0;
        end else begin
            reg_rdata_ff <= '0;
            if (reg_rd) begin
                case (reg_addr)
                    `GDP_ADDR_STS: reg_rdata_ff[`GDP_IRQ_W-1:0] <= sts_ff;
                    `GDP_ADDR_EN: reg_rdata_ff[`GDP_IRQ_W-1:0] <= en_ff;
                    `GDP_ADDR_CFG: begin
                        reg_rdata_ff[`GDP_CFG_OFS] <= offset_en_ff;
                        reg_rdata_ff[`GDP_CFG_BLK] <= disp_blank_ff;
                        reg_rdata_ff[`GDP_CFG_SFX] <= suffix_en_ff;
                        reg_rdata_ff[`GDP_CFG_TRM] <= term_sel_ff;
                        reg_rdata_ff[`GDP_CFG_MSK] <= srq_mask_ff;
                        reg_rdata_ff[`GDP_CFG_SRQ] <= srq_ff;
                    end
                    default: reg_rdata_ff <= '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking tp_cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    offset_capture_a: assert property (
        (commit && !dclr && pm.ofs_v && pm.ofs)
        |=> (offset_en_ff && offset_val_ff == $past(rdg_last_ff)))
        else $error("offset not captured from present reading");
    offset_cancel_a: assert property (
        (!offset_en_ff && rdg_vld) |=> (rdg_out_ff == $past(rdg_val)))
        else $error("cancelled offset still applied");
    clear_default_a: assert property (
        dclr |=> (!offset_en_ff && !disp_blank_ff && srq_mask_ff == `GDP_MASK_DEF
        && term_sel_ff == `GDP_TERM_DEF && !suffix_en_ff))
        else $error("device clear left a non default setting");
    display_blank_a: assert property (
        (commit && !dclr && pm.dsp_v) |=> (disp_blank_ff == $past(pm.dsp)))
        else $error("display command not applied");
    term_select_a: assert property (
        (commit && !dclr && tok.tok_vld && tok.tok_cmd == `GDP_CH_W
        && tok.tok_arg <= `GDP_TERM_MAX) |=> (term_sel_ff == $past(tok.tok_arg[2:0])))
        else $error("terminator choice not applied");
    srq_cause_a: assert property (
        $rose(srq_ff) |-> $past(srq_cond))
        else $error("service request without enabled condition");
    srq_dav_a: assert property (
        (srq_mask_ff[`GDP_MSK_DAV] && rdg_vld) |=> srq_ff)
        else $error("data available did not request service");
    srq_off_a: assert property (
        (srq_mask_ff == `GDP_MASK_DEF && !srq_ff && !dclr) |=> !$rose(srq_ff))
        else $error("service requested with mask zero");
    sticky_set_a: assert property (
        commit |=> sts_ff[`GDP_IRQ_EXEC])
        else $error("execute event not kept in status");
    query_bit_a: assert property (
        (commit && pm.qry_v && !dclr) |=> (qry_vld_ff && qry_ofs_ff == $past(offset_en_ff)))
        else $error("status query offset bit wrong");
endmodule : gdp_top

// File: tb/gdp_ctl_model.sv
// Bus controller model that talks command bytes to the interpreter
`timescale 1ns/1ps
module gdp_ctl_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Listener side of the interpreter
    output logic rx_vld = 1'b0,
    output logic [7:0] rx_byte = 8'h00,
    output logic rx_eoi = 1'b0,
    output logic rx_get = 1'b0,
    output logic rem_lsn = 1'b0
);
    task automatic send(input string s, input bit eoi);
        foreach (s[i]) begin
            @(posedge ref_clk);
            rem_lsn <= 1'b1;
            rx_vld <= 1'b1;
            rx_byte <= s[i];
            rx_eoi <= eoi && (i == s.len() - 1);
        end
        @(posedge ref_clk);
        rx_vld <= 1'b0;
        rx_eoi <= 1'b0;
        rem_lsn <= 1'b0;
        // Released data lines show junk, so a stale byte never looks valid
        rx_byte <= ~rx_byte;
    endtask : send
    // Group execute trigger message
    task automatic get();
        @(posedge ref_clk);
        rx_get <= 1'b1;
        @(posedge ref_clk);
        rx_get <= 1'b0;
    endtask : get
endmodule : gdp_ctl_model

// File: tb/gpib_device_command_parser_tb_top.sv
// Self-checking bench for the command interpreter
`timescale 1ns/1ps
module gpib_device_command_parser_tb_top;
    import gdp_pkg::*;
    logic ref_clk = 0, arst_n = 0, rx_vld, rx_eoi, rx_get, rem_lsn, rx_dev_clr = 0, srq_ack = 0;
    logic rdg_vld = 0, rdg_ovr = 0, meas_err = 0, reg_wr = 0, reg_rd = 0;
    logic rdg_out_vld_ff, offset_en_ff, disp_blank_ff, suffix_en_ff, srq_ff, meas_trig_ff;
    logic qry_vld_ff, qry_ofs_ff, irq_ff;
    logic signed [23:0] rdg_val = 0, rdg_out_ff, v, ofs;
    logic [2:0] term_sel_ff;
    logic [3:0] qry_code_ff, reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata_ff;
    gdp_byte_t rx_byte, srq_mask_ff;
    int n_errors = 0, checked = 0;
    int codes [3] = '{1, 16, 32};
    // Partner and design
    gdp_ctl_model u_ctl (.ref_clk, .arst_n, .rx_vld, .rx_byte, .rx_eoi, .rx_get, .rem_lsn);
    gdp_top #(.RW(24)) dut (.ref_clk, .arst_n, .rx_vld, .rx_byte, .rx_eoi, .rx_get,
        .rx_dev_clr, .rem_lsn, .srq_ack, .rdg_vld, .rdg_val, .rdg_ovr, .meas_err,
        .rdg_out_ff, .rdg_out_vld_ff, .offset_en_ff, .disp_blank_ff, .suffix_en_ff,
        .term_sel_ff, .srq_mask_ff, .srq_ff, .meas_trig_ff, .qry_vld_ff, .qry_code_ff,
        .qry_ofs_ff, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff, .irq_ff);
    // 40 MHz clock
    initial forever #12.5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic ck(input logic [31:0] g, input logic [31:0] e, input string m);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : ck
    task automatic conclude();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    // Send a command and let the two-stage commit settle
    task automatic cmd(input string s, input bit e = 0);
        u_ctl.send(s, e);
        repeat (4) @(posedge ref_clk);
        #1;
    endtask : cmd
    task automatic rd(input logic signed [23:0] x, input logic o);
        @(posedge ref_clk);
        rdg_vld <= 1'b1;
        rdg_val <= x;
        rdg_ovr <= o;
        @(posedge ref_clk);
        rdg_vld <= 1'b0;
        #1 ck(rdg_out_vld_ff, 1, "out valid");
    endtask : rd
    // Condition 0 overrange reading, 1 plain reading, 2 core error
    task automatic ev(input int k);
        if (k == 2) begin
            @(posedge ref_clk) meas_err <= 1'b1;
            @(posedge ref_clk) meas_err <= 1'b0;
        end else rd(24'($urandom_range(900)), k == 0);
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : ev
    task automatic rw(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : rw
    task automatic rr(input logic [3:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 ck(reg_rdata_ff, e, "reg read");
    endtask : rr
    // Pulses are one cycle long, so poll every cycle under a bound
    task automatic pw(input bit t);
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            #1;
            if ((t ? meas_trig_ff : qry_vld_ff) === 1'b1) return;
        end
        $display("[FAIL] %0t no pulse", $time);
        n_errors++;
        conclude();
    endtask : pw
    ////////////////////////////////////////////////////////////////////////////////
    // Hang guard
    initial begin
        #2000000;
        n_errors++;
        conclude();
    end
    // Main sequence
    initial begin
        void'($urandom(32'h3008));
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        #1 ck({offset_en_ff, disp_blank_ff, term_sel_ff, srq_mask_ff}, 0, "reset");
        v = 24'($urandom_range(5000));
        rd(v, 0);
        cmd("b1\n");
        ofs = v;
        ck(offset_en_ff, 1, "offset on");
        v = 24'($urandom_range(90000));
        rd(v, 0);
        ck(rdg_out_ff, v - ofs, "offset sub");
        cmd("B1\r");
        ofs = v;
        v = 24'($urandom_range(90000));
        rd(v, 0);
        ck(rdg_out_ff, v - ofs, "offset replace");
        u_ctl.send("g5\n", 0);
        pw(0);
        ck({qry_code_ff, qry_ofs_ff}, {4'h5, 1'b1}, "query");
        cmd("B0\n");
        rd(v, 0);
        ck(rdg_out_ff, v, "offset off");
        $display("test offset done");
        cmd("D1Y1W3\n");
        rr(4'hC, 32'h0000_001E);
        cmd("d0y0\n");
        ck({disp_blank_ff, suffix_en_ff}, 0, "normal");
        for (int i = 0; i < 6; i++) begin
            cmd((i % 2) ? $sformatf("w%0d", i) : $sformatf("W%0d\n", i), i % 2);
            ck(term_sel_ff, i, "term");
        end
        cmd("W6\n");
        ck(term_sel_ff, 5, "bad term");
        $display("test settings done");
        for (int i = 0; i < 3; i++) begin
            cmd($sformatf("N%0dP1\n", codes[i]));
            ck(srq_mask_ff, codes[i], "mask");
            ev((i + 1) % 3);
            ck(srq_ff, 0, "srq masked");
            ev(i);
            ck(srq_ff, 1, "srq raised");
            @(posedge ref_clk) srq_ack <= 1'b1;
            @(posedge ref_clk) srq_ack <= 1'b0;
            repeat (2) @(posedge ref_clk);
        end
        cmd("n33p1\n");
        ck(srq_mask_ff, 33, "sum mask");
        cmd("N0P1\n");
        ev(0);
        ck(srq_ff, 0, "srq off");
        $display("test srq done");
        u_ctl.send("D1", 0);
        u_ctl.get();
        pw(1);
        repeat (2) @(posedge ref_clk);
        ck(disp_blank_ff, 1, "get exec");
        cmd("B1\n");
        @(posedge ref_clk) rx_dev_clr <= 1'b1;
        @(posedge ref_clk) rx_dev_clr <= 1'b0;
        #1 ck({offset_en_ff, disp_blank_ff}, 0, "dev clear");
        cmd("B1D1\n");
        cmd("*");
        ck({offset_en_ff, disp_blank_ff}, 0, "star clear");
        $display("test clear done");
        rr(4'h0, 32'hF);
        rw(4'h4, 32'hF);
        rr(4'h0, 32'h0);
        rw(4'h8, 32'h2);
        rr(4'h8, 32'h2);
        rr(4'h2, 32'h0);
        cmd("Y1\n");
        ck(irq_ff, 1, "irq set");
        rw(4'h8, 32'h0);
        repeat (2) @(posedge ref_clk);
        #1 ck(irq_ff, 0, "irq masked");
        rw(4'h8, 32'h2);
        rw(4'h4, 32'h2);
        repeat (2) @(posedge ref_clk);
        #1 ck(irq_ff, 0, "irq cleared");
        $display("test regs done");
        conclude();
    end
endmodule : gpib_device_command_parser_tb_top
